/* File: logic/hwif_regs.svh */
// register offsets, bit positions and reset values of the interrupt flag group
`ifndef HWIF_REGS_SVH
`define HWIF_REGS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define HWIF_OFS_PENDING 8'h06
`define HWIF_OFS_ENABLE 8'h0F
`define HWIF_OFS_OUTEN 8'h13
// ------------------------------------------------------------
// bit positions
// ------------------------------------------------------------
`define HWIF_BIT_LOOP_A 12
`define HWIF_BIT_LOOP_B 11
`define HWIF_BIT_CTR_ROLL 9
`define HWIF_BIT_TERM_MATCH 7
`define HWIF_BIT_CTR_MATCH 5
`define HWIF_BIT_ADDR_PAR 3
`define HWIF_BIT_TERM_SUM 2
`define HWIF_BIT_CTR_SUM 0
// ------------------------------------------------------------
// masks and reset values
// ------------------------------------------------------------
`define HWIF_FLAG_MASK 16'h1AA8
`define HWIF_EN_RESET 16'h0008
`define HWIF_OE_RESET 16'h0008
`define HWIF_FULL16 16'hFFFF
`define HWIF_FULL32 32'hFFFFFFFF
`endif

/* File: logic/hwif_pkg.sv */
// types shared by the interrupt flag group
`default_nettype none
package hwif_pkg;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef logic [15:0] hwif_word_t; // one register or bus word
  typedef enum logic {HWIF_LB_IDLE, HWIF_LB_ARMED} hwif_lb_state_t; // echo checker
endpackage : hwif_pkg
`default_nettype wire

/* File: logic/hwif_loopback_chk.sv */
// loop-back echo checker for words sent by the remote terminal
`default_nettype none
module hwif_loopback_chk
  import hwif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rt_active,
  input wire logic tx_stb,
  input wire logic tx_bus_b,
  input wire logic tx_last,
  input wire hwif_word_t tx_data,
  input wire logic rx_stb,
  input wire logic rx_bus_b,
  input wire logic rx_sync_ok,
  input wire logic rx_enc_ok,
  input wire logic rx_bits_ok,
  input wire logic rx_par_ok,
  input wire hwif_word_t rx_data,
  output logic fail_a_q,
  output logic fail_b_q
);
  // ------------------------------------------------------------
  // decode of the echoed word
  // ------------------------------------------------------------
  hwif_lb_state_t state_q; // waiting for an echo or not
  logic exp_bus_b_q; // bus the word went out on
  logic exp_last_q; // last word of message
  hwif_word_t exp_data_q; // word as sent
  wire logic tx_take; // only terminal transmissions are checked
  wire logic echo_hit; // echo on the expected bus
  wire logic word_bad; // sync, coding, bit count, parity
  wire logic data_bad; // data compare on final word
  wire logic fail; // echo failed
  assign tx_take = tx_stb & rt_active; // R12
  assign echo_hit = (state_q == HWIF_LB_ARMED) & rx_stb & (rx_bus_b == exp_bus_b_q);
  assign word_bad = ~(rx_sync_ok & rx_enc_ok & rx_bits_ok & rx_par_ok); // R01
  assign data_bad = exp_last_q & (rx_data != exp_data_q); // R02
  assign fail = echo_hit & (word_bad | data_bad);
  // ------------------------------------------------------------
  // state and capture
  // ------------------------------------------------------------
  // a new word re-arms even if the last echo never came back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HWIF_LB_IDLE;
      exp_bus_b_q <= 1'b0;
      exp_last_q <= 1'b0;
      exp_data_q <= 16'h0000;
    end else begin
      case (state_q)
        HWIF_LB_IDLE: begin
          if (tx_take) begin
            state_q <= HWIF_LB_ARMED;
          end
        end
        HWIF_LB_ARMED: begin
          if (echo_hit && !tx_take) begin
            state_q <= HWIF_LB_IDLE;
          end
        end
        default: begin
          state_q <= HWIF_LB_IDLE;
        end
      endcase
      if (tx_take) begin
        exp_bus_b_q <= tx_bus_b;
        exp_last_q <= tx_last;
        exp_data_q <= tx_data;
      end
    end
  end
  // ------------------------------------------------------------
  // failure pulses
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_a_q <= 1'b0;
      fail_b_q <= 1'b0;
    end else begin
      fail_a_q <= fail & ~exp_bus_b_q; // R03
      fail_b_q <= fail & exp_bus_b_q; // R03
    end
  end
endmodule : hwif_loopback_chk
`default_nettype wire

/* File: logic/hwif_flags_low.sv */
// hardware interrupt flag group, bits 12 down to 0
// Functional notes
// R01 - echo words checked for sync, coding, count, parity
// R02 - final message word also compared data
// R03 - bus A/B echo failure sets bits 12/11
// R04 - controller counter wrap sets bit 9
// R05 - terminal counter reaching match sets bit 7
// R06 - controller counter reaching match sets bit 5
// R07 - even address parity at reset sets bit 3
// R08 - unused bits read zero, ignore writes
// R09 - enable/output-enable bits 2..0 read zero
// R10 - pending bit 2 summarises terminal pending
// R11 - pending bit 0 summarises controller pending
// R12 - echo failures only from terminal activity
// R13 - same event bits in all three registers
// R14 - enable gates pending; output-enable gates request
// R15 - flags stay until host writes one
// R16 - request is OR of enabled pending flags
`include "hwif_regs.svh"
`default_nettype none
module hwif_flags_low
  import hwif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire hwif_word_t reg_wdata,
  output hwif_word_t reg_rdata_q,
  input wire logic rt_active,
  input wire logic tx_stb,
  input wire logic tx_bus_b,
  input wire logic tx_last,
  input wire hwif_word_t tx_data,
  input wire logic rx_stb,
  input wire logic rx_bus_b,
  input wire logic rx_sync_ok,
  input wire logic rx_enc_ok,
  input wire logic rx_bits_ok,
  input wire logic rx_par_ok,
  input wire hwif_word_t rx_data,
  input wire logic bc_tt_inc,
  input wire logic bc_tt_wide,
  input wire logic [31:0] bc_tt_value,
  input wire logic [31:0] bc_tt_match,
  input wire logic rt_tt_inc,
  input wire hwif_word_t rt_tt_value,
  input wire hwif_word_t rt_tt_match,
  input wire logic [4:0] rt_addr,
  input wire logic rt_addr_par,
  input wire hwif_word_t rt_pending_reg,
  input wire hwif_word_t bc_pending_reg,
  output logic irq_q,
  output logic log_stb_q,
  output hwif_word_t log_bits_q
);
  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire logic sel_pend; // pending register addressed
  wire logic sel_en; // enable register addressed
  wire logic sel_oe; // output-enable register addressed
  wire logic wr_pend; // write-one-to-clear strobe
  wire logic wr_en; // enable write strobe
  wire logic wr_oe; // output-enable write strobe
  wire hwif_word_t flag_mask; // writable event bits
  assign flag_mask = `HWIF_FLAG_MASK;
  assign sel_pend = (reg_addr == `HWIF_OFS_PENDING);
  assign sel_en = (reg_addr == `HWIF_OFS_ENABLE);
  assign sel_oe = (reg_addr == `HWIF_OFS_OUTEN);
  assign wr_pend = reg_wr & sel_pend;
  assign wr_en = reg_wr & sel_en;
  assign wr_oe = reg_wr & sel_oe;

  // ------------------------------------------------------------
  // loop-back checker
  // ------------------------------------------------------------
  logic lb_fail_a; // bus A echo failed, one cycle
  logic lb_fail_b; // bus B echo failed, one cycle
  hwif_loopback_chk u_loopback (
    .clk(clk),
    .rst_n(rst_n),
    .rt_active(rt_active), // R12
    .tx_stb(tx_stb),
    .tx_bus_b(tx_bus_b),
    .tx_last(tx_last),
    .tx_data(tx_data),
    .rx_stb(rx_stb),
    .rx_bus_b(rx_bus_b),
    .rx_sync_ok(rx_sync_ok),
    .rx_enc_ok(rx_enc_ok),
    .rx_bits_ok(rx_bits_ok),
    .rx_par_ok(rx_par_ok),
    .rx_data(rx_data),
    .fail_a_q(lb_fail_a),
    .fail_b_q(lb_fail_b)
  );

  // ------------------------------------------------------------
  // time tag events
  // ------------------------------------------------------------
  wire logic [31:0] bc_next; // controller count after increment
  wire hwif_word_t rt_next; // terminal count after increment
  wire logic bc_full; // controller count at its top
  wire logic bc_hit; // controller count meets match
  wire logic ev_roll; // controller wrap event
  wire logic ev_bc_match; // controller match event
  wire logic ev_rt_match; // terminal match event
  assign bc_next = bc_tt_value + 32'h00000001;
  assign rt_next = rt_tt_value + 16'h0001;
  // narrow mode looks at the low half only
  assign bc_full = bc_tt_wide ? (bc_tt_value == `HWIF_FULL32)
                              : (bc_tt_value[15:0] == `HWIF_FULL16);
  assign bc_hit = bc_tt_wide ? (bc_next == bc_tt_match)
                             : (bc_next[15:0] == bc_tt_match[15:0]);
  assign ev_roll = bc_tt_inc & bc_full; // R04
  assign ev_bc_match = bc_tt_inc & bc_hit; // R06
  assign ev_rt_match = rt_tt_inc & (rt_next == rt_tt_match); // R05

  // ------------------------------------------------------------
  // address parity catch after reset
  // ------------------------------------------------------------
  logic par_seen_q; // parity already sampled
  logic ev_par_q; // parity fail pulse
  // sampled on the first edge after release, never under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_seen_q <= 1'b0;
      ev_par_q <= 1'b0;
    end else begin
      par_seen_q <= 1'b1;
      ev_par_q <= ~par_seen_q & ~(^{rt_addr, rt_addr_par}); // R07
    end
  end

  // ------------------------------------------------------------
  // event vector, same positions in all registers
  // ------------------------------------------------------------
  hwif_word_t ev_vec; // raw events by bit position
  always_comb begin
    ev_vec = 16'h0000; // R08
    ev_vec[`HWIF_BIT_LOOP_A] = lb_fail_a; // R03
    ev_vec[`HWIF_BIT_LOOP_B] = lb_fail_b; // R03
    ev_vec[`HWIF_BIT_CTR_ROLL] = ev_roll;
    ev_vec[`HWIF_BIT_TERM_MATCH] = ev_rt_match;
    ev_vec[`HWIF_BIT_CTR_MATCH] = ev_bc_match;
    ev_vec[`HWIF_BIT_ADDR_PAR] = ev_par_q;
  end

  // ------------------------------------------------------------
  // enable and output-enable registers
  // ------------------------------------------------------------
  hwif_word_t en_q; // event enables
  hwif_word_t oe_q; // request pin enables
  // only event bits are kept; bits 2..0 and spares stay zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= `HWIF_EN_RESET;
      oe_q <= `HWIF_OE_RESET;
    end else begin
      if (wr_en) begin
        en_q <= reg_wdata & flag_mask; // R09 R13
      end
      if (wr_oe) begin
        oe_q <= reg_wdata & flag_mask; // R09 R13
      end
    end
  end

  // ------------------------------------------------------------
  // pending flags, one per bit position
  // ------------------------------------------------------------
  hwif_word_t set_v; // enabled events this cycle
  hwif_word_t flag_d; // next flag state
  hwif_word_t flag_q; // sticky flags
  assign set_v = ev_vec & en_q & flag_mask; // R14
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      // set beats a clear landing in the same cycle
      assign flag_d[gi] = set_v[gi] | (flag_q[gi] & ~(wr_pend & reg_wdata[gi])); // R15
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_q[gi] <= 1'b0;
        end else begin
          flag_q[gi] <= flag_d[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // summary bits from the other pending registers
  // ------------------------------------------------------------
  logic rt_sum_q; // terminal register non-zero
  logic bc_sum_q; // controller register non-zero
  // follow the source registers; no clear from here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rt_sum_q <= 1'b0;
      bc_sum_q <= 1'b0;
    end else begin
      rt_sum_q <= |rt_pending_reg; // R10
      bc_sum_q <= |bc_pending_reg; // R11
    end
  end

  // ------------------------------------------------------------
  // read view
  // ------------------------------------------------------------
  hwif_word_t pend_view; // pending register as read
  wire hwif_word_t rd_mux; // selected register
  always_comb begin
    pend_view = flag_q & flag_mask; // R08
    pend_view[`HWIF_BIT_TERM_SUM] = rt_sum_q; // R10
    pend_view[`HWIF_BIT_CTR_SUM] = bc_sum_q; // R11
  end
  // unmapped addresses read zero
  assign rd_mux = sel_pend ? pend_view :
                  sel_en ? en_q :
                  sel_oe ? oe_q : 16'h0000;
  // read data lands one cycle after the strobe and holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // request pin and log strobe
  // ------------------------------------------------------------
  // built from next state so the pin tracks the flags without lag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      log_stb_q <= 1'b0;
      log_bits_q <= 16'h0000;
    end else begin
      irq_q <= |(flag_d & oe_q & flag_mask); // R14 R16
      log_stb_q <= |set_v; // R14
      log_bits_q <= set_v;
    end
  end
endmodule : hwif_flags_low
`default_nettype wire

/* File: tb/hwif_flags_chk_assertions.sv */
// concurrent checks on the ports of the interrupt flag group
`default_nettype none
module hwif_flags_chk
  import hwif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire hwif_word_t reg_rdata_q,
  input wire logic rx_stb,
  input wire logic rx_bus_b,
  input wire logic bc_tt_inc,
  input wire logic bc_tt_wide,
  input wire logic [31:0] bc_tt_value,
  input wire logic [31:0] bc_tt_match,
  input wire logic rt_tt_inc,
  input wire hwif_word_t rt_tt_value,
  input wire hwif_word_t rt_tt_match,
  input wire logic [4:0] rt_addr,
  input wire logic rt_addr_par,
  input wire hwif_word_t rt_pending_reg,
  input wire hwif_word_t bc_pending_reg,
  input wire logic irq_q,
  input wire logic log_stb_q,
  input wire hwif_word_t log_bits_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // decoded causes
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pnd_rd, en_rd, rt_hit, bc_hit, bc_roll, rt_any, bc_any, rx_a;
  assign pnd_rd = reg_rd && reg_addr == 8'h06;
  assign en_rd = reg_rd && (reg_addr == 8'h0F || reg_addr == 8'h13);
  assign rt_hit = rt_tt_inc && rt_tt_value + 16'h0001 == rt_tt_match;
  // narrow mode compares the low half only
  assign bc_hit = bc_tt_inc && (bc_tt_wide ? bc_tt_value + 32'h1 == bc_tt_match
                                : bc_tt_value[15:0] + 16'h1 == bc_tt_match[15:0]);
  assign bc_roll = bc_tt_inc && (bc_tt_wide ? &bc_tt_value : &bc_tt_value[15:0]);
  assign rt_any = |rt_pending_reg;
  assign bc_any = |bc_pending_reg;
  assign rx_a = rx_stb && !rx_bus_b;
  // ------------------------------------------------------------
  // assertions (read data is looked at two edges after the read,
  // so either read pipeline depth is accepted)
  // ------------------------------------------------------------
  chk_pend_zero:
  assert property (pnd_rd ##1 !reg_rd |=> (reg_rdata_q & 16'h0552) == 16'h0000)
    else $error("pending reserved bits not zero");
  chk_en_low:
  assert property (en_rd ##1 !reg_rd |=> (reg_rdata_q & 16'hE557) == 16'h0000)
    else $error("enable low bits not zero");
  chk_term_sum:
  assert property (pnd_rd && $stable(rt_any) && $past(rst_n, 2) ##1 !reg_rd
    |=> reg_rdata_q[2] == $past(rt_any, 2)) else $error("terminal summary wrong");
  chk_ctr_sum:
  assert property (pnd_rd && $stable(bc_any) && $past(rst_n, 2) ##1 !reg_rd
    |=> reg_rdata_q[0] == $past(bc_any, 2)) else $error("controller summary wrong");
  chk_parity_rst:
  assert property ($rose(rst_n) && !(^{rt_addr, rt_addr_par}) |-> ##2 irq_q)
    else $error("even address parity raised no request");
  chk_log_mask:
  assert property (log_stb_q |-> log_bits_q != 16'h0000 && (log_bits_q & ~16'h1AA8) == 16'h0000)
    else $error("log bits outside event set");
  chk_term_match:
  assert property (log_stb_q && log_bits_q[7] |-> $past(rt_hit) || $past(rt_hit, 2))
    else $error("terminal match logged without cause");
  chk_ctr_match:
  assert property (log_stb_q && log_bits_q[5] |-> $past(bc_hit) || $past(bc_hit, 2))
    else $error("controller match logged without cause");
  chk_ctr_roll:
  assert property (log_stb_q && log_bits_q[9] |-> $past(bc_roll) || $past(bc_roll, 2))
    else $error("rollover logged without wrap");
  chk_loop_a:
  assert property (log_stb_q && log_bits_q[12] |-> $past(rx_a, 2) || $past(rx_a, 3))
    else $error("bus A echo failure without echo word");
  chk_irq_drop:
  assert property ($fell(irq_q) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("request dropped without host write");
  cover property (log_stb_q && log_bits_q[12]);
  cover property (log_stb_q && log_bits_q[9]);
  cover property ($fell(irq_q));
endmodule : hwif_flags_chk
bind hwif_flags_low hwif_flags_chk i_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata_q, .rx_stb, .rx_bus_b, .bc_tt_inc, .bc_tt_wide, .bc_tt_value, .bc_tt_match,
  .rt_tt_inc, .rt_tt_value, .rt_tt_match, .rt_addr, .rt_addr_par, .rt_pending_reg,
  .bc_pending_reg, .irq_q, .log_stb_q, .log_bits_q);
`default_nettype wire

/* File: tb/hwif_bus_echo.sv */
// bus model that echoes each sent word back, optionally damaged
`default_nettype none
module hwif_bus_echo
  import hwif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_stb,
  input wire logic tx_bus_b,
  input wire hwif_word_t tx_data,
  input wire logic [2:0] fault,
  output logic rx_stb,
  output logic rx_bus_b,
  output logic [3:0] rx_ok,
  output hwif_word_t rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  hwif_word_t word_q; // word captured from the transmitter
  logic bus_q; // bus it went out on
  logic [1:0] send_q; // send seen one and two edges ago
  // ------------------------------------------------------------
  // echo: decoded word appears two edges after the send
  // ------------------------------------------------------------
  // a shift of send marks keeps the echo strobe to a single cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      send_q <= 2'b00;
      rx_stb <= 1'b0;
      rx_bus_b <= 1'b0;
      rx_ok <= 4'hF;
      rx_data <= 16'h0000;
    end else begin
      send_q <= {send_q[0], tx_stb};
      if (tx_stb) begin
        word_q <= tx_data;
        bus_q <= tx_bus_b;
      end
      rx_stb <= send_q[1];
      if (send_q[1]) begin
        rx_bus_b <= bus_q;
        rx_ok <= 4'hF & ~(4'h1 << (fault - 3'h1));
        rx_data <= word_q ^ {15'h0000, fault == 3'h5};
      end else begin
        rx_ok <= 4'hF;
        rx_data <= ~rx_data; // idle line inverts the last word on every cycle
      end
    end
  end
endmodule : hwif_bus_echo
`default_nettype wire

/* File: tb/hwif_flags_low_tb_top.sv */
// self-checking bench for the interrupt flag group
`default_nettype none
module hwif_flags_low_tb_top
  import hwif_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rt_active = 1'b0;
  logic tx_stb = 1'b0, tx_bus_b = 1'b0, tx_last = 1'b0, bc_tt_inc = 1'b0, bc_tt_wide = 1'b0;
  logic rt_tt_inc = 1'b0, rt_addr_par = 1'b0, rx_stb, rx_bus_b, irq_q, log_stb_q;
  logic [7:0] reg_addr = 8'h00;
  logic [4:0] rt_addr = 5'h03; // even parity with rt_addr_par low
  logic [2:0] fault = 3'h0;
  logic [3:0] rx_ok;
  logic [31:0] bc_tt_value = 32'h0, bc_tt_match = 32'h5;
  hwif_word_t reg_wdata = 16'h0, tx_data = 16'h0, rt_tt_value = 16'h0, rt_tt_match = 16'h1234;
  hwif_word_t rt_pending_reg = 16'h0, bc_pending_reg = 16'h0, rx_data, reg_rdata_q, log_bits_q;
  int bad_count = 0, num_checks = 0;
  always #50 clk = ~clk;
  hwif_flags_low i_dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
    .rt_active, .tx_stb, .tx_bus_b, .tx_last, .tx_data, .rx_stb, .rx_bus_b,
    .rx_sync_ok(rx_ok[3]), .rx_enc_ok(rx_ok[2]), .rx_bits_ok(rx_ok[1]), .rx_par_ok(rx_ok[0]),
    .rx_data, .bc_tt_inc, .bc_tt_wide, .bc_tt_value, .bc_tt_match, .rt_tt_inc, .rt_tt_value,
    .rt_tt_match, .rt_addr, .rt_addr_par, .rt_pending_reg, .bc_pending_reg, .irq_q,
    .log_stb_q, .log_bits_q);
  hwif_bus_echo i_echo (.clk, .rst_n, .tx_stb, .tx_bus_b, .tx_data, .fault, .rx_stb,
    .rx_bus_b, .rx_ok, .rx_data);
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input hwif_word_t exp, input hwif_word_t got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input hwif_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read data stands from the edge after the strobe; looked at later on a falling edge
  task automatic rd(input logic [7:0] a, input hwif_word_t exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("rdata", exp, reg_rdata_q);
  endtask : rd
  task automatic irq(input logic exp);
    @(negedge clk);
    chk("irq", {15'h0000, exp}, {15'h0000, irq_q});
  endtask : irq
  // log outputs stand for the cycle after an increment edge
  task automatic lg(input hwif_word_t exp);
    @(negedge clk);
    chk("log_bits", exp, log_bits_q);
    chk("log_stb", {15'h0000, exp != 16'h0000}, {15'h0000, log_stb_q});
  endtask : lg
  // one counter increment pulse, value given before the step
  task automatic tt(input logic bc, input logic wide, input logic [31:0] v);
    @(posedge clk);
    bc_tt_wide <= wide;
    bc_tt_value <= v;
    rt_tt_value <= v[15:0];
    bc_tt_inc <= bc;
    rt_tt_inc <= !bc;
    @(posedge clk);
    bc_tt_inc <= 1'b0;
    rt_tt_inc <= 1'b0;
  endtask : tt
  // send one word, let the echo return, read the flags
  task automatic lb(input logic act, input logic bus, input logic last, input logic [2:0] f,
                    input hwif_word_t exp);
    wr(8'h06, 16'hFFFF);
    @(posedge clk);
    rt_active <= act;
    tx_bus_b <= bus;
    tx_last <= last;
    fault <= f;
    tx_data <= 16'hA5C3;
    tx_stb <= 1'b1;
    @(posedge clk);
    tx_stb <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'h06, exp);
  endtask : lb
  task automatic results;
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    irq(1'b1);
    rd(8'h06, 16'h0008);
    rd(8'h0F, 16'h0008);
    rd(8'h13, 16'h0008);
    wr(8'h06, 16'h0008);
    rd(8'h06, 16'h0000);
    irq(1'b0);
    wr(8'h0F, 16'h0000);
    tt(1'b0, 1'b0, 32'h00001233);
    lg(16'h0000);
    rd(8'h06, 16'h0000);
    wr(8'h0F, 16'hFFFF);
    wr(8'h13, 16'h0000);
    rd(8'h0F, 16'h1AA8);
    rd(8'h20, 16'h0000);
    tt(1'b0, 1'b0, 32'h00001233);
    lg(16'h0080);
    tt(1'b0, 1'b0, 32'h00001234);
    rd(8'h06, 16'h0080);
    irq(1'b0);
    wr(8'h13, 16'hFFFF);
    rd(8'h13, 16'h1AA8);
    irq(1'b1);
    wr(8'h06, 16'h0080);
    irq(1'b0);
    tt(1'b1, 1'b0, 32'h0000FFFF);
    lg(16'h0200);
    tt(1'b1, 1'b1, 32'h0000FFFF);
    rd(8'h06, 16'h0200);
    wr(8'h06, 16'hFFFF);
    tt(1'b1, 1'b1, 32'hFFFFFFFF);
    rd(8'h06, 16'h0200);
    wr(8'h06, 16'hFFFF);
    tt(1'b1, 1'b0, 32'h00010004);
    lg(16'h0020);
    rd(8'h06, 16'h0020);
    wr(8'h06, 16'hFFFF);
    rt_pending_reg <= 16'h0100;
    bc_pending_reg <= 16'h8000;
    rd(8'h06, 16'h0005);
    irq(1'b0);
    @(posedge clk);
    rt_pending_reg <= 16'h0000;
    bc_pending_reg <= 16'h0000;
    rd(8'h06, 16'h0000);
    for (int f = 0; f < 6; f++) begin
      lb(1'b1, 1'b0, 1'b1, 3'(f), (f != 0) ? 16'h1000 : 16'h0000);
    end
    lb(1'b1, 1'b0, 1'b0, 3'h5, 16'h0000);
    lb(1'b1, 1'b1, 1'b1, 3'h1, 16'h0800);
    lb(1'b0, 1'b0, 1'b1, 3'h1, 16'h0000);
    results();
  end
endmodule : hwif_flags_low_tb_top
`default_nettype wire
